// [include/rtcie_pkg.sv]
// Shared constants, types and helpers of the RTC interrupt-enable and
// clock-select block.
// Assumes a 50 MHz core clock and a 32.768 kHz subclock input.
package rtcie_pkg;

    // ----
    // Bus and register map
    // ----
    localparam int AVS_AW = 6;
    localparam logic [5:0] OFS_IRQ_EN = 6'h00;
    localparam logic [5:0] OFS_CLK_SRC = 6'h04;
    localparam logic [5:0] OFS_CTRL1 = 6'h08;
    localparam logic [5:0] OFS_FLAG = 6'h0c;
    localparam logic [5:0] OFS_SECONDS = 6'h10;
    localparam logic [5:0] OFS_PORT_MODE = 6'h14;
    localparam logic [5:0] OFS_IRQ_STATUS = 6'h18;
    localparam logic [5:0] OFS_IRQ_CLEAR = 6'h1c;

    // ----
    // Field positions and reset values
    // ----
    localparam int CTRL_RUN_BIT = 7;
    localparam int CTRL_SRST_BIT = 4;
    localparam int PMR_CLKOUT_BIT = 0;
    localparam logic [7:0] CSR_RESET = 8'h08;
    localparam logic [7:0] IRQ_EN_RESET = 8'h00;
    localparam logic [3:0] SRC_FRC_SYS8 = 4'h0;
    localparam logic [3:0] SRC_RTC_SUB4 = 4'h8;
    localparam int FRC_BASE_SHIFT = 3;
    localparam int OUT_DIV4_BIT = 1;

    // ----
    // Timing counts
    // ----
    localparam int CLK_HZ = 50000000;
    localparam int SUB_HZ = 32768;
    localparam int SUB_PRESCALE = 4;
    localparam int TICK_HZ = SUB_HZ / SUB_PRESCALE;
    localparam int RTC_QSEC_TICKS = TICK_HZ / 4;
    localparam int SYS_DIV_W = 10;
    localparam logic [5:0] SEC_MAX = 6'h3b;
    localparam logic [5:0] MIN_MAX = 6'h3b;
    localparam logic [4:0] HOUR_MAX = 5'h17;
    localparam logic [2:0] DOW_MAX = 3'h6;

    // ----
    // Types
    // ----
    typedef enum logic [2:0] {
        PM_ACTIVE, PM_SLEEP, PM_SUBACTIVE, PM_SUBSLEEP, PM_WATCH, PM_STANDBY
    } rtcie_pwr_mode_t;

    // Bit order matches the enable and flag registers, bit 7 first.
    typedef struct packed {
        logic ovf;
        logic week;
        logic day;
        logic hour;
        logic minute;
        logic second;
        logic half;
        logic quarter;
    } rtcie_events_t;

    typedef struct packed {
        logic rsvd;
        logic [2:0] out_sel;
        logic [3:0] src;
    } rtcie_csr_t;

    // ----
    // Helpers
    // ----
    // Codes 1001 to 1111 are refused as count clock selections.
    function automatic logic src_prohibited(input logic [3:0] code);
        src_prohibited = code[3] && (code[2:0] != 3'h0);
    endfunction

    // Divided system clocks run only while the core clock runs.
    function automatic logic pwr_sys_ok(input rtcie_pwr_mode_t m);
        pwr_sys_ok = (m == PM_ACTIVE) || (m == PM_SLEEP);
    endfunction

    function automatic logic pwr_sub_ok(input rtcie_pwr_mode_t m);
        pwr_sub_ok = (m != PM_STANDBY);
    endfunction

endpackage

// [src/rtcie_clkdiv.sv]
// System clock prescaler, subclock divide-by-four tick and clock output.
// Assumes the subclock input is synchronous to the core clock.
`timescale 1ns/1ns
module rtcie_clkdiv
    import rtcie_pkg::*;
#(
    parameter int DIV_W = SYS_DIV_W
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic sub_in,
    input wire logic out_on,
    input wire logic [2:0] out_sel,
    input wire rtcie_pwr_mode_t pwr_mode,
    output logic [DIV_W-1:0] div_cnt,
    output logic sub_tick,
    output logic clk_out
);

    // The divide-by-32 output needs five prescaler bits.
    if (DIV_W < 5)
    begin : g_bad_width
        $error("rtcie_clkdiv: DIV_W must be at least 5");
    end

    logic sub_q;
    logic [1:0] sub_pre_q;
    logic sub_rise;
    int unsigned sys_idx;

    // Free-running prescaler of the core clock.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            div_cnt <= '0;
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // Every fourth subclock rising edge gives one count tick.
    assign sub_rise = sub_in && !sub_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sub_q <= 1'b0;
            sub_pre_q <= 2'h0;
            sub_tick <= 1'b0;
        end
        else
        begin
            sub_q <= sub_in;
            sub_tick <= sub_rise && (sub_pre_q == 2'(SUB_PRESCALE - 1));
            if (sub_rise)
                sub_pre_q <= sub_pre_q + 2'h1;
        end
    end

    // Codes 000, 010, 100, 110 pick /4, /8, /16, /32; xx1 the subclock.
    assign sys_idx = int'(out_sel[2:1]) + OUT_DIV4_BIT;

    // Output is held low in power modes where its source is stopped.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            clk_out <= 1'b0;
        else if (!out_on)
            clk_out <= 1'b0;
        else if (out_sel[0])
            clk_out <= sub_q && pwr_sub_ok(pwr_mode);
        else
            clk_out <= div_cnt[sys_idx] && pwr_sys_ok(pwr_mode);
    end

    a_sys_out_gated: assert property (
        @(posedge clk) disable iff (!nrst)
        $past(out_on && !out_sel[0] && !pwr_sys_ok(pwr_mode))
        |-> !clk_out)
        else $error("divided clock driven outside active or sleep");

endmodule

// [src/rtcie_timekeep.sv]
// Timekeeping counters, periodic events and the 8-bit free-running
// counter. Assumes one-cycle tick pulses from the prescaler.
`timescale 1ns/1ns
module rtcie_timekeep
    import rtcie_pkg::*;
#(
    parameter int QSEC_TICKS = RTC_QSEC_TICKS
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic run,
    input wire logic rtc_mode,
    input wire logic sub_tick,
    input wire logic frc_tick,
    output rtcie_events_t events,
    output logic [7:0] seconds_val
);

    if (QSEC_TICKS < 2)
    begin : g_bad_ticks
        $error("rtcie_timekeep: QSEC_TICKS must be at least 2");
    end

    localparam int PRE_W = $clog2(QSEC_TICKS);

    logic [PRE_W-1:0] pre_q;
    logic [1:0] qtr_q;
    logic [5:0] sec_q;
    logic [5:0] min_q;
    logic [4:0] hr_q;
    logic [2:0] dow_q;
    logic [7:0] frc_q;
    logic cnt_en, qtr_w, sec_w, min_w, hr_w, day_w, frc_inc;

    // Timekeeping runs only on the subclock/4 selection.
    assign cnt_en = run && rtc_mode && sub_tick;
    assign qtr_w = cnt_en && (pre_q == PRE_W'(QSEC_TICKS - 1));
    assign sec_w = qtr_w && (qtr_q == 2'h3);
    assign min_w = sec_w && (sec_q == SEC_MAX);
    assign hr_w = min_w && (min_q == MIN_MAX);
    assign day_w = hr_w && (hr_q == HOUR_MAX);
    assign frc_inc = run && !rtc_mode && frc_tick;

    // Calendar chain, binary coded, cleared by the soft reset.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            pre_q <= '0;
            qtr_q <= 2'h0;
            sec_q <= 6'h00;
            min_q <= 6'h00;
            hr_q <= 5'h00;
            dow_q <= 3'h0;
        end
        else if (clr)
        begin
            pre_q <= '0;
            qtr_q <= 2'h0;
            sec_q <= 6'h00;
            min_q <= 6'h00;
            hr_q <= 5'h00;
            dow_q <= 3'h0;
        end
        else if (cnt_en)
        begin
            pre_q <= qtr_w ? '0 : pre_q + 1'b1;
            if (qtr_w)
                qtr_q <= qtr_q + 2'h1;
            if (sec_w)
                sec_q <= min_w ? 6'h00 : sec_q + 6'h01;
            if (min_w)
                min_q <= hr_w ? 6'h00 : min_q + 6'h01;
            if (hr_w)
                hr_q <= day_w ? 5'h00 : hr_q + 5'h01;
            if (day_w)
                dow_q <= (dow_q == DOW_MAX) ? 3'h0 : dow_q + 3'h1;
        end
    end

    // Free-running counter wraps from ff to 00.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            frc_q <= 8'h00;
        else if (clr)
            frc_q <= 8'h00;
        else if (frc_inc)
            frc_q <= frc_q + 8'h01;
    end

    // Events are one-cycle pulses, registered to keep the fan-out clean.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            events <= '0;
        else
        begin
            events.ovf <= frc_inc && (frc_q == 8'hff) && !clr;
            events.week <= day_w && (dow_q == DOW_MAX) && !clr;
            events.day <= day_w && !clr;
            events.hour <= hr_w && !clr;
            events.minute <= min_w && !clr;
            events.second <= sec_w && !clr;
            events.half <= qtr_w && qtr_q[0] && !clr;
            events.quarter <= qtr_w && !clr;
        end
    end

    // Seconds register shows the counter value in free-running mode.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            seconds_val <= 8'h00;
        else
            seconds_val <= rtc_mode ? {2'h0, sec_q} : frc_q;
    end

    a_week_at_zero: assert property (
        @(posedge clk) disable iff (!nrst)
        events.week |-> (dow_q == 3'h0))
        else $error("week event without day-of-week at zero");

endmodule

// [src/rtcie_top.sv]
// Top of the RTC interrupt-enable and clock-select block: Avalon-MM
// register slave, interrupt flags and the clock source decode.
// Assumes an Avalon-MM master on CORE_CLK and a synchronous subclock.
`timescale 1ns/1ns
module rtcie_top
    import rtcie_pkg::*;
#(
    parameter int QSEC_TICKS = RTC_QSEC_TICKS
)
(
    input wire logic CORE_CLK,
    input wire logic NRST,
    input wire logic [AVS_AW-1:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SUBCLK,
    input wire rtcie_pwr_mode_t POWER_MODE,
    output logic CLOCK_OUTPUT_PIN,
    output logic IRQ
);

    // ----
    // Register state
    // ----
    logic ack_q;
    logic [7:0] irq_en_q;
    rtcie_csr_t csr_q;
    logic run_q;
    logic srst_q;
    logic [7:0] flags_q;
    logic [7:0] flags_d;
    logic pmr_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // ----
    // Internal wiring
    // ----
    logic wr_ok;
    logic rd_start;
    logic [7:0] wd;
    logic [7:0] flag_clr;
    logic [7:0] flag_set;
    logic rtc_mode;
    logic frc_tick;
    logic sub_tick;
    logic [SYS_DIV_W-1:0] div_cnt;
    logic [7:0] seconds_val;
    rtcie_events_t events;

    // ----
    // Avalon-MM handshake
    // ----
    // One wait state per access; the data for a read is latched in the
    // first cycle so the answer does not depend on a late mux.
    assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !ack_q;
    assign wr_ok = AVS_WRITE && ack_q && AVS_BYTEENABLE[0];
    assign rd_start = AVS_READ && !ack_q;
    assign wd = AVS_WRITEDATA[7:0];

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            ack_q <= 1'b0;
        else
            ack_q <= (AVS_READ || AVS_WRITE) && !ack_q;
    end

    // Read mux; unmapped addresses and write-only registers read zero.
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            rdata_q <= 32'h00000000;
        else if (rd_start)
        begin
            case (AVS_ADDRESS)
                OFS_IRQ_EN: rdata_q <= {24'h000000, irq_en_q};
                OFS_CLK_SRC: rdata_q <= {24'h000000, 1'b0,
                                         csr_q[6:0]};
                OFS_CTRL1: rdata_q <= {24'h000000, run_q, 2'h0, srst_q,
                                       4'h0};
                OFS_FLAG: rdata_q <= {24'h000000, flags_q};
                OFS_SECONDS: rdata_q <= {24'h000000, seconds_val};
                OFS_PORT_MODE: rdata_q <= {31'h00000000, pmr_q};
                OFS_IRQ_STATUS: rdata_q <= {24'h000000, flags_q};
                default: rdata_q <= 32'h00000000;
            endcase
        end
    end
    assign AVS_READDATA = rdata_q;

    // ----
    // Control register one and port mode
    // ----
    // The soft reset bit itself is only changed by software writes.
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            run_q <= 1'b0;
            srst_q <= 1'b0;
        end
        else if (wr_ok && AVS_ADDRESS == OFS_CTRL1)
        begin
            run_q <= wd[CTRL_RUN_BIT] && !wd[CTRL_SRST_BIT];
            srst_q <= wd[CTRL_SRST_BIT];
        end
        else if (srst_q)
            run_q <= 1'b0;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            pmr_q <= 1'b0;
        else if (wr_ok && AVS_ADDRESS == OFS_PORT_MODE)
            pmr_q <= wd[PMR_CLKOUT_BIT];
    end

    // ----
    // Interrupt enable register
    // ----
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            irq_en_q <= IRQ_EN_RESET;
        else if (srst_q)
            irq_en_q <= IRQ_EN_RESET;
        else if (wr_ok && AVS_ADDRESS == OFS_IRQ_EN)
            irq_en_q <= wd;
    end

    // ----
    // Clock source select register
    // ----
    // Survives the soft reset. A prohibited source code is refused and
    // the old code kept, so the counter never sees an undefined clock.
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            csr_q <= rtcie_csr_t'(CSR_RESET);
        else if (wr_ok && AVS_ADDRESS == OFS_CLK_SRC)
        begin
            csr_q.rsvd <= 1'b0;
            csr_q.out_sel <= wd[6:4];
            if (!src_prohibited(wd[3:0]))
                csr_q.src <= wd[3:0];
        end
    end

    // Only 1000 keeps time; 0000 counts system clock/8 and 0001..0111
    // each halve that rate again, down to system clock/1024.
    assign rtc_mode = (csr_q.src == SRC_RTC_SUB4);
    assign frc_tick = &div_cnt[FRC_BASE_SHIFT +
                               int'(csr_q.src[2:0]) - 1 -: 1]
                      && &(div_cnt | ~(SYS_DIV_W'((1 << (FRC_BASE_SHIFT
                      + int'(csr_q.src[2:0]))) - 1)));

    // ----
    // Interrupt flags
    // ----
    // Software clears with a 0 in the flag register or a 1 in the clear
    // register; a new event in the same cycle wins over the clear.
    assign flag_set = events & irq_en_q;
    always_comb
    begin
        flag_clr = 8'h00;
        if (wr_ok && AVS_ADDRESS == OFS_FLAG)
            flag_clr = ~wd;
        else if (wr_ok && AVS_ADDRESS == OFS_IRQ_CLEAR)
            flag_clr = wd;
        flags_d = (flags_q & ~flag_clr) | flag_set;
    end

    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            flags_q <= 8'h00;
        else if (srst_q)
            flags_q <= 8'h00;
        else
            flags_q <= flags_d;
    end

    // Level interrupt, high while an enabled flag is set.
    always_ff @(posedge CORE_CLK or negedge NRST)
    begin
        if (!NRST)
            irq_q <= 1'b0;
        else
            irq_q <= |(flags_q & irq_en_q);
    end
    assign IRQ = irq_q;

    // ----
    // Submodules
    // ----
    rtcie_clkdiv #(
        .DIV_W(SYS_DIV_W)
    ) u_clkdiv (
        .clk(CORE_CLK),
        .nrst(NRST),
        .sub_in(SUBCLK),
        .out_on(pmr_q),
        .out_sel(csr_q.out_sel),
        .pwr_mode(POWER_MODE),
        .div_cnt(div_cnt),
        .sub_tick(sub_tick),
        .clk_out(CLOCK_OUTPUT_PIN)
    );

    rtcie_timekeep #(
        .QSEC_TICKS(QSEC_TICKS)
    ) u_timekeep (
        .clk(CORE_CLK),
        .nrst(NRST),
        .clr(srst_q),
        .run(run_q),
        .rtc_mode(rtc_mode),
        .sub_tick(sub_tick),
        .frc_tick(frc_tick),
        .events(events),
        .seconds_val(seconds_val)
    );

    // ----
    // Assertions
    // ----
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    a_ovf_gate: assert property (
        $rose(flags_q[7]) |-> $past(irq_en_q[7]))
        else $error("overflow flag set while disabled");

    a_periodic_gate: assert property (
        (flags_q[6:0] & ~$past(flags_q[6:0]) & ~$past(irq_en_q[6:0]))
        == 7'h00)
        else $error("periodic flag set while disabled");

    a_flag_set: assert property (
        (flag_set != 8'h00 && !srst_q)
        |=> ((flags_q & $past(flag_set)) == $past(flag_set)))
        else $error("enabled event did not set its flag");

    a_srst_clear: assert property (
        srst_q |=> (irq_en_q == 8'h00) && (flags_q == 8'h00)
        && (!run_q || $past(wr_ok && AVS_ADDRESS == OFS_CTRL1)))
        else $error("soft reset left enables or flags set");

    a_frc_no_periodic: assert property (
        !rtc_mode |=> (events[6:0] == 7'h00))
        else $error("periodic event in free-running mode");

    a_stop_holds: assert property (
        (!run_q && !srst_q) ##1 ($stable(rtc_mode) && !run_q)
        ##1 $stable(rtc_mode) |-> $stable(seconds_val))
        else $error("counter moved while stopped");

    a_seconds_read: assert property (
        (rd_start && AVS_ADDRESS == OFS_SECONDS)
        |=> AVS_READDATA[7:0] == $past(seconds_val))
        else $error("seconds read returned wrong value");

    a_ovf_irq: assert property (
        (events.ovf && irq_en_q[7] && !srst_q)
        |=> flags_q[7] ##1 (IRQ || !$past(irq_en_q[7])))
        else $error("enabled overflow did not raise interrupt");

    a_src_refused: assert property (
        (wr_ok && AVS_ADDRESS == OFS_CLK_SRC && src_prohibited(wd[3:0]))
        |=> $stable(csr_q.src))
        else $error("prohibited source code accepted");

    a_rsvd_zero: assert property (
        (rd_start && AVS_ADDRESS == OFS_CLK_SRC) |=> !AVS_READDATA[7])
        else $error("reserved select bit read as one");

    a_flag_hold: assert property (
        (($past(flags_q) & ~flags_q) != 8'h00)
        |-> $past(flag_clr != 8'h00 || srst_q))
        else $error("flag dropped without a clear");

    a_one_wait: assert property (
        (AVS_READ || AVS_WRITE) && !ack_q |=> !AVS_WAITREQUEST)
        else $error("bus access not answered after one wait state");

    c_periodic_flag: cover property (flag_set[6:0] != 7'h00);
    c_ovf_flag: cover property (events.ovf && irq_en_q[7]);
    c_week_event: cover property (events.week);
    c_clear_race: cover property (|(flag_clr & flag_set));

endmodule

// [testbench/rtcie_top_bench.sv]
// Self-checking bench for the RTC interrupt-enable and clock-select top.
// Assumes a subclock of 4 core cycles; every bus wait is bounded here.
`timescale 1ns/1ns
module rtcie_top_bench
    import rtcie_pkg::*;
;
    // ----
    // Stimulus signals
    // ----
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [AVS_AW-1:0] addr = '0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic subclk = 1'b0;
    logic [1:0] sub_cnt = 2'h0;
    rtcie_pwr_mode_t pmode = PM_ACTIVE;
    logic clk_pin;
    logic irq;
    int bad_count = 0;
    int checks = 0;
    logic [7:0] a;
    logic [7:0] b;
    logic [3:0] be = 4'hf;

    // Core clock at 50 MHz.
    always #10 core_clk = ~core_clk;

    // Subclock toggles every two core cycles, so one rising edge per four cycles.
    always @(posedge core_clk)
    begin
        sub_cnt <= sub_cnt + 2'h1;
        subclk <= sub_cnt[1];
    end

    rtcie_top #(.QSEC_TICKS(4)) dut (
        .CORE_CLK(core_clk),
        .NRST(rst_n),
        .AVS_ADDRESS(addr),
        .AVS_READ(rd),
        .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata),
        .AVS_BYTEENABLE(be),
        .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(waitreq),
        .SUBCLK(subclk),
        .POWER_MODE(pmode),
        .CLOCK_OUTPUT_PIN(clk_pin),
        .IRQ(irq)
    );

    // ----
    // Tasks
    // ----
    // Prints the verdict once and ends the run.
    task automatic report_and_stop();
        if (bad_count == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic timeout(input string what);
        bad_count++;
        $display("wrong value %s expected done seen timeout", what);
        report_and_stop();
    endtask

    task automatic check(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One Avalon access; the request is held until waitrequest is seen
    // low at a rising edge, which is also where read data is taken.
    task automatic bus(input logic w, input logic [5:0] ad,
        input logic [7:0] d, output logic [7:0] q);
        int k;
        k = 0;
        @(posedge core_clk);
        wr <= w;
        rd <= ~w;
        addr <= ad;
        wdata <= {24'h0, d};
        // Waitrequest and read data are taken at the same rising edge.
        do
        begin
            @(posedge core_clk);
            k++;
            if (k > 20)
                timeout("bus");
        end
        while (waitreq !== 1'b0);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [5:0] ad, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, ad, d, q);
    endtask

    task automatic rchk(input logic [5:0] ad, input logic [7:0] exp,
        input string what);
        logic [7:0] q;
        bus(1'b0, ad, 8'h00, q);
        check(what, exp, q);
    endtask

    // Bounded wait for the interrupt line to reach a level.
    task automatic wait_irq(input logic lvl, input int limit);
        int k;
        k = 0;
        while (irq !== lvl)
        begin
            @(negedge core_clk);
            k++;
            if (k > limit)
                timeout("irq");
        end
    endtask

    // Rising edges of the output pin over 128 cycles, after settling.
    task automatic rises(input logic [7:0] exp);
        logic prev;
        int c;
        c = 0;
        repeat (8) @(negedge core_clk);
        prev = clk_pin;
        repeat (128)
        begin
            @(negedge core_clk);
            if (clk_pin === 1'b1 && prev === 1'b0)
                c++;
            prev = clk_pin;
        end
        check("pin rises", exp, c[7:0]);
        // Return on a rising edge so the next input change lands there.
        @(posedge core_clk);
    endtask

    // ----
    // Main sequence
    // ----
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rchk(OFS_IRQ_EN, 8'h00, "enable reset");
        rchk(OFS_CLK_SRC, 8'h08, "select reset");
        rchk(6'h20, 8'h00, "unmapped");
        wreg(OFS_IRQ_EN, 8'hff);
        rchk(OFS_IRQ_EN, 8'hff, "enable all");
        // A write with the low byte lane disabled must not land.
        be <= 4'he;
        wreg(OFS_IRQ_EN, 8'h00);
        be <= 4'hf;
        rchk(OFS_IRQ_EN, 8'hff, "byte enable");
        // A prohibited source code is refused while bit 7 stays zero.
        wreg(OFS_CLK_SRC, 8'hff);
        rchk(OFS_CLK_SRC, 8'h78, "select ff");
        wreg(OFS_CTRL1, 8'h10);
        rchk(OFS_IRQ_EN, 8'h00, "soft reset");
        rchk(OFS_CLK_SRC, 8'h78, "select kept");
        wreg(OFS_CTRL1, 8'h00);
        // Counter rates: 160 cycles between the two latching edges.
        for (int i = 0; i < 3; i++)
        begin
            wreg(OFS_CLK_SRC, i[7:0]);
            wreg(OFS_CTRL1, 8'h80);
            bus(1'b0, OFS_SECONDS, 8'h00, a);
            repeat (157) @(posedge core_clk);
            bus(1'b0, OFS_SECONDS, 8'h00, b);
            check("count step", 8'h14 >> i, b - a);
            wreg(OFS_CTRL1, 8'h00);
            bus(1'b0, OFS_SECONDS, 8'h00, a);
            repeat (40) @(posedge core_clk);
            bus(1'b0, OFS_SECONDS, 8'h00, b);
            check("stopped", a, b);
        end
        // Overflow interrupt: raise, mask, refuse write of one, clear.
        wreg(OFS_IRQ_EN, 8'h80);
        wreg(OFS_CLK_SRC, 8'h00);
        wreg(OFS_CTRL1, 8'h80);
        wait_irq(1'b1, 2300);
        wreg(OFS_CTRL1, 8'h00);
        rchk(OFS_FLAG, 8'h80, "ovf flag");
        rchk(OFS_IRQ_STATUS, 8'h80, "status");
        wreg(OFS_IRQ_EN, 8'h00);
        wait_irq(1'b0, 5);
        wreg(OFS_FLAG, 8'hff);
        rchk(OFS_FLAG, 8'h80, "flag write one");
        wreg(OFS_IRQ_EN, 8'h80);
        wait_irq(1'b1, 5);
        wreg(OFS_FLAG, 8'h7f);
        rchk(OFS_FLAG, 8'h00, "flag write zero");
        wait_irq(1'b0, 5);
        // Timekeeping with the half-second event blocked.
        wreg(OFS_CTRL1, 8'h10);
        wreg(OFS_CTRL1, 8'h00);
        wreg(OFS_CLK_SRC, 8'h08);
        wreg(OFS_IRQ_EN, 8'h05);
        wreg(OFS_CTRL1, 8'h80);
        wait_irq(1'b1, 200);
        repeat (300) @(posedge core_clk);
        wreg(OFS_CTRL1, 8'h00);
        rchk(OFS_FLAG, 8'h05, "periodic flags");
        wreg(OFS_IRQ_CLEAR, 8'h05);
        rchk(OFS_FLAG, 8'h00, "irq clear");
        wait_irq(1'b0, 5);
        // Clock output selections and power modes.
        wreg(OFS_PORT_MODE, 8'h01);
        for (int i = 0; i < 4; i++)
        begin
            wreg(OFS_CLK_SRC, {1'b0, i[1:0], 5'h08});
            rises(8'h20 >> i);
        end
        wreg(OFS_CLK_SRC, 8'h18);
        rises(8'h20);
        pmode <= PM_WATCH;
        rises(8'h20);
        wreg(OFS_CLK_SRC, 8'h08);
        rises(8'h00);
        pmode <= PM_SLEEP;
        rises(8'h20);
        pmode <= PM_STANDBY;
        wreg(OFS_CLK_SRC, 8'h18);
        rises(8'h00);
        pmode <= PM_ACTIVE;
        wreg(OFS_PORT_MODE, 8'h00);
        rises(8'h00);
        report_and_stop();
    end
endmodule
